// File: logic/parp_ctrl.sv
// Controller that drives the preprocessor board from the analyzer side
// and from the host bus side, ordered by software over APB.
// Assumes the board answers reads on cable_data within one strobe width.
//
// Functional notes
// - Identity read qualified by one low pulse
// - Write 4300H loads processor ID, low strobe
// - Write 6000H gives low preprocessor clear
// - Write analyzer_data_strobe strobes low byte pattern
`timescale 1ns/1ps
module parp_ctrl
  import parp_pkg::*;
(
  input  wire logic              pclk,                       // Clock, 100 MHz
  input  wire logic              presetn,                    // Async reset, low
  // APB slave
  input  wire logic              psel,                       // Select
  input  wire logic              penable,                    // Access phase
  input  wire logic              pwrite,                     // Write
  input  wire logic [11:0]       paddr,                      // Byte address
  input  wire logic [31:0]       pwdata,                     // Write data
  output logic      [31:0]       prdata,                     // Read data
  output logic                   pready,                     // Ready
  output logic                   pslverr,                    // Unmapped address
  output logic                   irq,                        // Level interrupt
  // Host bus side of the board
  output logic      [15:0]       bus_addr,                   // Address
  output logic      [7:0]        bus_data,                   // Data, inverted
  output logic                   proc_ident_write_strobe_n,  // 4300H write
  output logic                   data_write_strobe_n,        // analyzer_data_strobe write
  // Analyzer interface cable
  output logic                   board_ident_read_strobe_n,  // Identity read
  output logic                   status_read_strobe_n,       // Status read
  output logic                   proc_ident_read_strobe_n,   // Processor ID read
  output logic                   master_reset_strobe_n,      // Master reset
  output logic                   halt_qualify_clear_n,       // Preprocessor clear
  output logic                   stimulus_n,                 // Stimulus line
  output logic                   halt_n,                     // Halt line
  input  wire logic [7:0]        cable_data,                 // Read data, inverted
  input  wire logic              analyzer_clock_high,        // Clock channel 0 high
  input  wire logic              analyzer_clock_low,         // Clock channel 0 low
  input  wire logic [CHAN_W-1:0] chan_data                   // Analyzer channels
);
  import parp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Synchronisers
  localparam int SW = 8 + 2 + CHAN_W;
  logic [SW-1:0]     sync_q;               // Synchronised pins
  logic [7:0]        cable_s;              // Cable data
  logic              ack_hi_s;             // High clock line
  logic              ack_lo_s;             // Low clock line
  logic [CHAN_W-1:0] chan_s;               // Channels

  parp_sync #(.W(SW)) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({chan_data, analyzer_clock_low, analyzer_clock_high, cable_data}),
    .sync_out (sync_q)
  );
  assign cable_s  = sync_q[7:0];
  assign ack_hi_s = sync_q[8];
  assign ack_lo_s = sync_q[9];
  assign chan_s   = sync_q[SW-1:10];

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_PULSE} parp_state_t;

  // Low-true strobe mask for an operation
  function automatic logic [SB_W-1:0] op_strobe(input parp_op_t op);
    logic [SB_W-1:0] m;
    m = SB_IDLE;
    case (op)
      OP_BOARD_ID:    m[SB_BOARD] = 1'b0;
      OP_STATUS:      m[SB_STAT]  = 1'b0;
      OP_PROC_ID_RD:  m[SB_PIDRD] = 1'b0;
      OP_MASTER_RST:  m[SB_MRST]  = 1'b0;
      OP_PREPROC_CLR: m[SB_CLR]   = 1'b0;
      OP_PROC_ID_WR:  m[SB_PIDWR] = 1'b0;
      OP_DATA_STROBE: m[SB_DSTB]  = 1'b0;
      default:        m = SB_IDLE;
    endcase
    return m;
  endfunction : op_strobe

  parp_state_t     state, next_state;         // Sequencer state
  parp_op_t        op, next_op;               // Operation in flight
  logic [SB_W-1:0] strobe, next_strobe;       // Strobe pins
  logic [15:0]     next_bus_addr;             // Next address
  logic [7:0]      next_bus_data;             // Next data
  logic [7:0]      rd_data, next_rd_data;     // Last read, true sense
  logic            busy, next_busy;           // Operation in flight
  logic            done_ev;                   // Operation finished
  logic            tmr_load;                  // Timer load
  logic [TMR_W-1:0] tmr_val;                  // Timer value
  logic            tmr_zero;                  // Timer run out
  logic            cmd_wr;                    // Command written
  logic            apb_wr;                    // APB write taken
  logic [TMR_W-1:0] id_low_cnt, next_id_low_cnt;  // Identity strobe low cycles

  parp_timer #(.W(TMR_W)) u_tmr (
    .pclk     (pclk),
    .presetn  (presetn),
    .load     (tmr_load),
    .load_val (tmr_val),
    .zero     (tmr_zero)
  );

  // Next sequencer values; a command while busy is dropped
  always_comb begin
    next_state    = state;
    next_op       = op;
    next_strobe   = strobe;
    next_bus_addr = bus_addr;
    next_bus_data = bus_data;
    next_rd_data  = rd_data;
    next_busy     = busy;
    done_ev       = 1'b0;
    tmr_load      = 1'b0;
    tmr_val       = '0;
    next_id_low_cnt = board_ident_read_strobe_n ? '0 : id_low_cnt + 1'b1;
    case (state)
      ST_IDLE: begin
        if (cmd_wr) begin
          next_op   = parp_op_t'(pwdata[CMD_OP_LSB +: 3]);
          next_busy = (next_op != OP_NONE);
          tmr_load  = 1'b1;
          tmr_val   = TMR_W'(SETUP_CYC - 1);
          next_bus_data = ~pwdata[CMD_DATA_LSB +: 8];  // Low-true on the wires
          if (next_op == OP_DATA_STROBE) begin
            // Pattern rides in the low address byte
            next_bus_addr = {ADDR_DATA_STROBE[15:8], pwdata[CMD_DATA_LSB +: 8]};
          end else if (next_op == OP_PROC_ID_WR) begin
            next_bus_addr = ADDR_PROC_ID_WR;
          end
          if (next_busy) begin
            next_state = ST_SETUP;
          end
        end
      end
      ST_SETUP: begin
        if (tmr_zero) begin
          // Exactly one low pulse per operation
          next_strobe = op_strobe(op);
          tmr_load    = 1'b1;
          tmr_val     = TMR_W'(STROBE_CYC - 1);
          next_state  = ST_PULSE;
        end
      end
      ST_PULSE: begin
        if (tmr_zero) begin
          // Capture before release; read has no side effect
          if (op == OP_BOARD_ID || op == OP_STATUS || op == OP_PROC_ID_RD) begin
            next_rd_data = ~cable_s;
          end
          next_strobe = SB_IDLE;
          next_busy   = 1'b0;
          done_ev     = 1'b1;
          next_state  = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // Register sequencer state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state    <= ST_IDLE;
      op       <= OP_NONE;
      strobe   <= SB_IDLE;
      bus_addr <= '0;
      bus_data <= '0;
      rd_data  <= '0;
      busy     <= 1'b0;
      id_low_cnt <= '0;
    end else begin
      state    <= next_state;
      op       <= next_op;
      strobe   <= next_strobe;
      bus_addr <= next_bus_addr;
      bus_data <= next_bus_data;
      rd_data  <= next_rd_data;
      busy     <= next_busy;
      id_low_cnt <= next_id_low_cnt;
    end
  end

  assign board_ident_read_strobe_n = strobe[SB_BOARD];
  assign status_read_strobe_n      = strobe[SB_STAT];
  assign proc_ident_read_strobe_n  = strobe[SB_PIDRD];
  assign master_reset_strobe_n     = strobe[SB_MRST];
  assign halt_qualify_clear_n      = strobe[SB_CLR];
  assign proc_ident_write_strobe_n = strobe[SB_PIDWR];
  assign data_write_strobe_n       = strobe[SB_DSTB];

  ////////////////////////////////////////////////////////////////////////////
  // Analyzer clock watch
  logic              hi_d;                     // High line, last cycle
  logic [31:0]       clk_cnt, next_clk_cnt;    // Analyzer clocks seen
  logic [CHAN_W-1:0] chan_q, next_chan_q;      // Channels at last clock
  logic              aclk_ev;                  // Analyzer clock edge

  // One count per rising high line while low line is down
  always_comb begin
    aclk_ev      = ack_hi_s && !hi_d && !ack_lo_s;
    next_clk_cnt = aclk_ev ? clk_cnt + 32'h1 : clk_cnt;
    next_chan_q  = aclk_ev ? chan_s : chan_q;  // Load-mode pattern
  end

  // Register clock watch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_d    <= 1'b0;
      clk_cnt <= '0;
      chan_q  <= '0;
    end else begin
      hi_d    <= ack_hi_s;
      clk_cnt <= next_clk_cnt;
      chan_q  <= next_chan_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB registers and interrupt
  logic [IRQ_W-1:0] irq_stat, next_irq_stat;   // Sticky events
  logic [IRQ_W-1:0] irq_en, next_irq_en;       // Enables
  logic [1:0]       lines, next_lines;         // Stimulus and halt asks
  logic [31:0]      next_prdata;               // Next read data
  logic             next_pready;               // Next ready
  logic             next_pslverr;              // Next error
  logic             next_irq;                  // Next interrupt
  logic             mapped;                    // Address decodes
  logic [IRQ_W-1:0] clr;                       // Clear request

  // Decode in setup phase, answer one cycle later
  always_comb begin
    apb_wr      = psel && penable && pready && pwrite;
    cmd_wr      = apb_wr && (paddr == OFF_CMD);
    next_prdata = '0;
    mapped      = 1'b1;
    if (paddr == OFF_CMD) begin
      next_prdata = '0;
    end else if (paddr == OFF_STAT) begin
      next_prdata[STAT_BUSY]          = busy;
      next_prdata[STAT_RD_LSB +: 8]   = rd_data;
    end else if (paddr == OFF_CLKCNT) begin
      next_prdata = clk_cnt;
    end else if (paddr == OFF_CHAN_LO) begin
      next_prdata = chan_q[31:0];
    end else if (paddr == OFF_CHAN_HI) begin
      next_prdata[CHAN_W-33:0] = chan_q[CHAN_W-1:32];
    end else if (paddr == OFF_IRQ_STAT) begin
      next_prdata[IRQ_W-1:0] = irq_stat;
    end else if (paddr == OFF_IRQ_CLR) begin
      next_prdata = '0;
    end else if (paddr == OFF_IRQ_EN) begin
      next_prdata[IRQ_W-1:0] = irq_en;
    end else if (paddr == OFF_LINES) begin
      next_prdata[1:0] = lines;
    end else begin
      mapped = 1'b0;
    end
    next_pready  = psel && !penable;
    next_pslverr = psel && !penable && !mapped;
    clr          = (apb_wr && paddr == OFF_IRQ_CLR) ? pwdata[IRQ_W-1:0] : '0;
    next_irq_stat = (irq_stat & ~clr) | {aclk_ev, done_ev};  // Set beats clear
    next_irq_en   = (apb_wr && paddr == OFF_IRQ_EN) ? pwdata[IRQ_W-1:0] : irq_en;
    next_lines    = (apb_wr && paddr == OFF_LINES) ? pwdata[1:0] : lines;
    next_irq      = |(next_irq_stat & next_irq_en);
  end

  // Register bus state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata     <= '0;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      irq_stat   <= '0;
      irq_en     <= '0;
      lines      <= '0;
      irq        <= 1'b0;
      stimulus_n <= 1'b1;
      halt_n     <= 1'b1;
    end else begin
      prdata     <= next_prdata;
      pready     <= next_pready;
      pslverr    <= next_pslverr;
      irq_stat   <= next_irq_stat;
      irq_en     <= next_irq_en;
      lines      <= next_lines;
      irq        <= next_irq;
      // Break sources the board gates by its control bits
      stimulus_n <= !next_lines[LINE_STIM];
      halt_n     <= !next_lines[LINE_HALT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks; a pulse too long or too short shows in the low count at its end
  a_id_read_pulse: assert property (
    $rose(board_ident_read_strobe_n) |-> (id_low_cnt == TMR_W'(STROBE_CYC)))
    else $error("identity read strobe width wrong");

  a_pid_write_addr: assert property (
    !proc_ident_write_strobe_n |->
      (bus_addr == ADDR_PROC_ID_WR) && $stable(bus_data) && $stable(bus_addr))
    else $error("processor ID write address or data moved");

  a_clear_alone: assert property (
    $fell(halt_qualify_clear_n) |->
      (&strobe[SB_MRST:0]) && (strobe == op_strobe(OP_PREPROC_CLR))
      ##[1:12] $rose(halt_qualify_clear_n))
    else $error("preprocessor clear pulse not single or not ended");

  a_strobe_pattern: assert property (
    $fell(data_write_strobe_n) |->
      bus_addr[15:8] == ADDR_DATA_STROBE[15:8] && $past(bus_addr) == bus_addr)
    else $error("data strobe address not in 47xx range");

endmodule : parp_ctrl

// File: logic/parp_pkg.sv
// Constants shared by the preprocessor analyzer port controller.
// Assumes a 100 MHz pclk and 32-bit APB for the controller's own registers.
package parp_pkg;

  // Clock and pulse timing
  localparam int CLK_PERIOD_NS = 10;   // pclk period
  localparam int SETUP_NS      = 30;   // address/data ahead of a strobe
  localparam int STROBE_NS     = 100;  // least width of a low-true strobe
  localparam int SETUP_CYC     = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC    = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W         = 8;    // timer width

  // Device addresses
  localparam logic [15:0] ADDR_PROC_ID_WR  = 16'h4300;
  localparam logic [15:0] ADDR_DATA_STROBE = 16'h4700;
  localparam logic [15:0] ADDR_BOARD_ID    = 16'h6000;
  localparam logic [15:0] ADDR_STATUS      = 16'h6001;
  localparam logic [15:0] ADDR_PROC_ID_RD  = 16'h6002;
  localparam logic [15:0] ADDR_MASTER_RST  = 16'h6003;

  // Analyzer channels
  localparam int CHAN_W = 48;

  // Controller register offsets
  localparam logic [11:0] OFF_CMD      = 12'h000;
  localparam logic [11:0] OFF_STAT     = 12'h004;
  localparam logic [11:0] OFF_CLKCNT   = 12'h008;
  localparam logic [11:0] OFF_CHAN_LO  = 12'h00c;
  localparam logic [11:0] OFF_CHAN_HI  = 12'h010;
  localparam logic [11:0] OFF_IRQ_STAT = 12'h014;
  localparam logic [11:0] OFF_IRQ_CLR  = 12'h018;
  localparam logic [11:0] OFF_IRQ_EN   = 12'h01c;
  localparam logic [11:0] OFF_LINES    = 12'h020;

  // Field positions
  localparam int CMD_DATA_LSB = 0;
  localparam int CMD_OP_LSB   = 8;
  localparam int STAT_BUSY    = 0;
  localparam int STAT_RD_LSB  = 8;
  localparam int IRQ_DONE     = 0;
  localparam int IRQ_ACLK     = 1;
  localparam int IRQ_W        = 2;
  localparam int LINE_STIM    = 0;
  localparam int LINE_HALT    = 1;

  // Operations that software can order
  typedef enum logic [2:0] {
    OP_BOARD_ID, OP_STATUS, OP_PROC_ID_RD, OP_MASTER_RST,
    OP_PREPROC_CLR, OP_PROC_ID_WR, OP_DATA_STROBE, OP_NONE
  } parp_op_t;

  // Strobe vector bit positions
  localparam int SB_BOARD = 0;
  localparam int SB_STAT  = 1;
  localparam int SB_PIDRD = 2;
  localparam int SB_MRST  = 3;
  localparam int SB_CLR   = 4;
  localparam int SB_PIDWR = 5;
  localparam int SB_DSTB  = 6;
  localparam int SB_W     = 7;
  localparam logic [SB_W-1:0] SB_IDLE = 7'h7f;

endpackage : parp_pkg

// File: logic/parp_sync.sv
// Two-flop synchroniser for a bundle of asynchronous levels.
// Assumes each bit is an independent level; words need their own handshake.
`timescale 1ns/1ps
module parp_sync #(
  parameter int W = 1                     // Number of bits
) (
  input  wire logic         pclk,         // Clock
  input  wire logic         presetn,      // Async reset, low
  input  wire logic [W-1:0] async_in,     // Raw pins
  output logic      [W-1:0] sync_out      // Synchronised levels
);
  logic [W-1:0] meta;                     // First stage, read only below

  // Two stages; only the second is seen by logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule : parp_sync

// File: logic/parp_timer.sv
// Loadable down counter that times setup and strobe phases.
// Assumes the load value is at least one.
`timescale 1ns/1ps
module parp_timer #(
  parameter int W = 8                     // Counter width
) (
  input  wire logic         pclk,         // Clock
  input  wire logic         presetn,      // Async reset, low
  input  wire logic         load,         // Start a new count
  input  wire logic [W-1:0] load_val,     // Cycles minus one
  output logic              zero          // Count has run out
);
  logic [W-1:0] count;                    // Remaining cycles
  logic [W-1:0] next_count;               // Next count

  // Count down, stick at zero
  always_comb begin
    next_count = count;
    if (load) begin
      next_count = load_val;
    end else if (count != '0) begin
      next_count = count - 1'b1;
    end
  end

  // Register only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign zero = (count == '0);
endmodule : parp_timer

// File: test/parp_board_model.sv
// Behavioural model of the preprocessor board as the controller sees it.
// Assumes strobes are low-true levels and host and cable data are negative true on wires.
`timescale 1ns/1ps
module parp_board_model
  import parp_pkg::*;
#(
  parameter logic [7:0] BOARD_ID  = 8'h3c,  // Arbitrary identity value
  parameter logic [7:0] STAT_BASE = 8'h5a,  // Fixed status bits 7..1
  parameter logic [7:0] CTRL_WORD = 8'h8c,  // Load mode, both breaks enabled
  parameter int         HI_BYTE   = 4       // Channel byte sent inverted
) (
  input  wire logic              pclk,                       // Sampling clock
  input  wire logic              presetn,                    // Power-on reset
  input  wire logic [15:0]       bus_addr,                   // Host address
  input  wire logic [7:0]        bus_data,                   // Host data
  input  wire logic              proc_ident_write_strobe_n,  // ID write
  input  wire logic              data_write_strobe_n,        // Data strobe
  input  wire logic              board_ident_read_strobe_n,  // Identity read
  input  wire logic              status_read_strobe_n,       // Status read
  input  wire logic              proc_ident_read_strobe_n,   // ID read
  input  wire logic              master_reset_strobe_n,      // Master reset
  input  wire logic              halt_qualify_clear_n,       // Clear pulse
  input  wire logic              stimulus_n,                 // Stimulus line
  input  wire logic              halt_n,                     // Halt line
  output logic      [7:0]        cable_data,                 // Read data
  output logic                   analyzer_clock_high,        // Clock line high
  output logic                   analyzer_clock_low,         // Clock line low
  output logic      [CHAN_W-1:0] chan_data                   // Channels
);
  logic [7:0] pid_wire;  // Processor ID as stored, negative true
  logic       brk;       // Break state
  logic       armed;     // Halt line qualified by a clear
  logic [7:0] pat;       // Pattern from the strobe address

  ////////////////////////////////////////////////////////////////////////
  // Board state; master reset overrides every other update
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pid_wire <= 8'h00;
      brk      <= 1'b0;
      armed    <= 1'b0;
    end else if (!master_reset_strobe_n) begin
      pid_wire <= 8'h00;
      brk      <= 1'b0;
      armed    <= 1'b0;
    end else begin
      if (!proc_ident_write_strobe_n) pid_wire <= bus_data;
      if (!halt_qualify_clear_n) armed <= 1'b1;
      if ((!stimulus_n && CTRL_WORD[3]) || (!halt_n && CTRL_WORD[2] && armed)) begin
        brk <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Cable data; unselected lines keep toggling so stale data never passes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cable_data <= 8'h00;
    else if (!board_ident_read_strobe_n) cable_data <= ~BOARD_ID;
    else if (!status_read_strobe_n) cable_data <= ~{STAT_BASE[7:1], brk};
    else if (!proc_ident_read_strobe_n) cable_data <= pid_wire;
    else cable_data <= ~cable_data;
  end

  ////////////////////////////////////////////////////////////////////////
  // One strobe gives one clock on both lines of clock channel zero
  assign analyzer_clock_high = ~data_write_strobe_n;
  assign analyzer_clock_low  = data_write_strobe_n;
  assign pat = CTRL_WORD[7] ? bus_addr[7:0] : 8'h00;
  for (genvar i = 0; i < CHAN_W / 8; i++) begin : g_byte
    assign chan_data[8*i +: 8] = (i == HI_BYTE) ? ~pat : pat;
  end
endmodule : parp_board_model

// File: test/preprocessor_analyzer_register_port_test.sv
// Self-checking bench: APB orders to the controller, board model beyond.
// Assumes the controller answers every APB access and reports busy in STAT.
`timescale 1ns/1ps
module preprocessor_analyzer_register_port_test;
  import parp_pkg::*;
  localparam logic [7:0] BID   = 8'h3c;  // Arbitrary identity value
  localparam logic [7:0] SBASE = 8'h5a;  // Model's fixed status bits
  localparam int         HIB   = 4;      // Inverted channel byte

  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;  // APB address
  logic [31:0] pwdata = 32'h0, prdata, rd, tmp;  // Bus data and captures
  logic pready, pslverr, irq, err, pwn, dsn, bidn, stn, pidn, mrn, hqn, stim, hlt, ach, acl;
  logic [15:0] bus_addr;  // Host address
  logic [7:0] bus_data, cable_data, pat;  // Data lines
  logic [CHAN_W-1:0] chan_data;  // Channels
  int n_fail = 0, num_checks = 0, cycles = 0;  // Counters

  always #5 pclk = ~pclk;

  parp_ctrl u_parp_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .bus_addr(bus_addr), .bus_data(bus_data),
    .proc_ident_write_strobe_n(pwn), .data_write_strobe_n(dsn),
    .board_ident_read_strobe_n(bidn), .status_read_strobe_n(stn),
    .proc_ident_read_strobe_n(pidn), .master_reset_strobe_n(mrn),
    .halt_qualify_clear_n(hqn), .stimulus_n(stim), .halt_n(hlt), .cable_data(cable_data),
    .analyzer_clock_high(ach), .analyzer_clock_low(acl), .chan_data(chan_data));
  parp_board_model #(.BOARD_ID(BID), .STAT_BASE(SBASE), .CTRL_WORD(8'h8c), .HI_BYTE(HIB))
  u_parp_board_model (.pclk(pclk), .presetn(presetn), .bus_addr(bus_addr),
    .bus_data(bus_data), .proc_ident_write_strobe_n(pwn), .data_write_strobe_n(dsn),
    .board_ident_read_strobe_n(bidn), .status_read_strobe_n(stn),
    .proc_ident_read_strobe_n(pidn), .master_reset_strobe_n(mrn),
    .halt_qualify_clear_n(hqn), .stimulus_n(stim), .halt_n(hlt), .cable_data(cable_data),
    .analyzer_clock_high(ach), .analyzer_clock_low(acl), .chan_data(chan_data));

  ////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic check(input logic [47:0] got, input logic [47:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // One APB transfer, held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // Order one device operation and poll until it is finished
  task automatic run(input parp_op_t op, input logic [7:0] d);
    apb(1'b1, OFF_CMD, {21'h0, op, d});
    apb(1'b0, OFF_STAT, 32'h0);
    while (rd[STAT_BUSY] !== 1'b0) apb(1'b0, OFF_STAT, 32'h0);
  endtask : run

  // Pulse the break lines through the controller
  task automatic lines(input logic [31:0] v);
    apb(1'b1, OFF_LINES, v);
    apb(1'b1, OFF_LINES, 32'h0);
  endtask : lines

  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  ////////////////////////////////////////////////////////////////////////
  // Hang guard: the sequence needs a few thousand cycles at most
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 8000) begin
      n_fail++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    run(OP_BOARD_ID, 8'h00); check(rd[15:8], BID);
    run(OP_STATUS, 8'h00); check(rd[15:8], {SBASE[7:1], 1'b0});
    run(OP_PROC_ID_WR, 8'ha5); check({bus_addr, bus_data}, {ADDR_PROC_ID_WR, 8'h5a});
    repeat (2) begin
      run(OP_PROC_ID_RD, 8'h00); check(rd[15:8], 8'ha5);
    end
    lines(32'h1);
    run(OP_STATUS, 8'h00); check(rd[15:8], {SBASE[7:1], 1'b1});
    run(OP_MASTER_RST, 8'h00);
    run(OP_PROC_ID_RD, 8'h00); check(rd[15:8], 8'hff);
    run(OP_STATUS, 8'h00); check(rd[15:8], {SBASE[7:1], 1'b0});
    // Halt break stays off until the clear pulse has qualified the line
    lines(32'h2);
    run(OP_STATUS, 8'h00); check(rd[15:8], {SBASE[7:1], 1'b0});
    run(OP_PREPROC_CLR, 8'h00);
    lines(32'h2);
    run(OP_STATUS, 8'h00); check(rd[15:8], {SBASE[7:1], 1'b1});
    // Data strobes: each address pattern lands on every channel byte, inverted on byte HIB
    for (int i = 0; i < 21; i++) begin
      pat = (i == 20) ? 8'hff : 8'(i * 37);
      run(OP_DATA_STROBE, pat);
      check(bus_addr, {8'h47, pat});
      apb(1'b0, OFF_CHAN_LO, 32'h0);
      tmp = rd;
      apb(1'b0, OFF_CHAN_HI, 32'h0);
      check({rd[15:0], tmp}, {{(5 - HIB){pat}}, ~pat, {HIB{pat}}});
    end
    apb(1'b0, OFF_CLKCNT, 32'h0); check(rd, 32'h15);
    // Interrupt: enabled, cleared, then masked
    apb(1'b1, OFF_IRQ_CLR, 32'h3);
    apb(1'b1, OFF_IRQ_EN, 32'h1);
    run(OP_STATUS, 8'h00);
    @(posedge pclk);
    check(irq, 1'b1);
    apb(1'b1, OFF_IRQ_CLR, 32'h1);
    check(irq, 1'b0);
    apb(1'b1, OFF_IRQ_EN, 32'h0);
    run(OP_STATUS, 8'h00);
    @(posedge pclk);
    check(irq, 1'b0);
    apb(1'b0, OFF_IRQ_STAT, 32'h0);
    check(rd[IRQ_W-1:0], 2'h1);
    apb(1'b0, 12'h100, 32'h0);
    check(err, 1'b1);
    give_verdict();
  end
endmodule : preprocessor_analyzer_register_port_test
